/* dfp_dsp_model.sv */
`default_nettype none
// processor memory bus master, one strobe cycle per call
module dfp_dsp_model (
    input  wire logic        core_clk,
    input  wire logic [15:0] busRdData,
    output logic      [21:0] busAddr,
    output logic      [15:0] busWrData,
    output logic             busWr,
    output logic             busRd,
    output logic      [3:0]  space
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] rdVal;
    // idle bus from time zero
    initial begin
        {busAddr, busWrData, busWr, busRd, space, rdVal} = '0;
    end
    // space is {program, io, data, byte}; all held until the sampling edge
    task automatic xfer(input logic wr, input logic [3:0] sp, input logic [21:0] a,
                        input logic [15:0] d);
        @(posedge core_clk);
        busWr <= wr;
        busRd <= !wr;
        space <= sp;
        busAddr <= a;
        busWrData <= d;
        @(posedge core_clk);
        busWr <= 1'b0;
        busRd <= 1'b0;
        space <= 4'h0;
        busWrData <= ~d; // released data must not linger
        #1 rdVal = busRdData;
    endtask
endmodule // dfp_dsp_model
`default_nettype wire

/* dfp_logic_array.sv */
`default_nettype none
module dfp_logic_array #(
    parameter logic [2*dfp_pkg::ARR_IN*dfp_pkg::CELLS*dfp_pkg::TERMS-1:0] TERM_MASK = '0,
    parameter logic [dfp_pkg::CELLS*dfp_pkg::TERMS-1:0]                   TERM_USE  = '0,
    parameter logic [dfp_pkg::CELLS-1:0]                                  OMC_REG   = '0,
    parameter logic [2*dfp_pkg::CELLS-1:0]                                IMC_MODE  = '0
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [31:0] extIn,
    input  wire logic [15:0] pinSync,
    input  wire logic        imcClkEn,
    input  wire logic        imcGate,
    input  wire logic [1:0]  omcLoadEn,
    input  wire logic [7:0]  omcLoadData,
    output logic      [15:0] omcOut,
    output logic      [15:0] imcOut
);
    logic [15:0]  imcFf;
    logic [15:0]  omcFf;
    logic [15:0]  orSum;
    logic [63:0]  arrIn;
    logic [127:0] lit;

    // true and complemented forms of every array input
    assign arrIn = {extIn, imcOut, omcOut};
    assign lit   = {~arrIn, arrIn};

    genvar c, t;
    generate
        for (c = 0; c < dfp_pkg::CELLS; c++) begin : g_cell
            logic [dfp_pkg::TERMS-1:0] pTerm;
            for (t = 0; t < dfp_pkg::TERMS; t++) begin : g_term
                // one AND term; cleared mask bits leave a literal out
                assign pTerm[t] = &(lit | ~TERM_MASK[(c*dfp_pkg::TERMS+t)*128 +: 128]);
            end
            // or of up to ten terms per output cell
            assign orSum[c] = |(pTerm & TERM_USE[c*dfp_pkg::TERMS +: dfp_pkg::TERMS]);
            // combinatorial or registered output, fed back always
            assign omcOut[c] = OMC_REG[c] ? omcFf[c] : orSum[c];
            // pass, clocked or latched pin input
            assign imcOut[c] = (IMC_MODE[2*c +: 2] == 2'b00) ? pinSync[c] : imcFf[c];
        end
    endgenerate

    // output cell flip-flops; software load wins over logic
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            omcFf <= dfp_pkg::RST_HALF;
        end else begin
            for (int i = 0; i < dfp_pkg::CELLS; i++) begin
                if (omcLoadEn[i/8]) begin
                    omcFf[i] <= omcLoadData[i%8];
                end else begin
                    omcFf[i] <= orSum[i];
                end
            end
        end
    end

    // input cell capture: clock mode on divider pulse, latch while gate high
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            imcFf <= dfp_pkg::RST_HALF;
        end else begin
            for (int i = 0; i < dfp_pkg::CELLS; i++) begin
                if ((IMC_MODE[2*i +: 2] == 2'b01 && imcClkEn) ||
                    (IMC_MODE[2*i +: 2] == 2'b10 && imcGate)) begin
                    imcFf[i] <= pinSync[i];
                end
            end
        end
    end
endmodule // dfp_logic_array
`default_nettype wire

/* dfp_memory.sv */
`default_nettype none
// Function
// - flash is 128K bytes in eight 16K sectors, each selected by decode.
// - byte strobe, data strobe and io strobe serve; program strobe is ignored.
// - data path is 8 bits; all 22 address lines are decoded.
// - data strobe accesses carry the byte in bits 15..8 only.
// - security bit set blocks external programmer reads and writes.
// - security bit clears only when a full device erase completes.
// - processor reads flash whatever the security bit says.
// - processor can erase one sector or the whole array.
// - flash stands by whenever no processor access is in progress.
// - logic runs fast or low-power; low-power idles while inputs hold.
// - decode selects at most one sector or the control block.
// - decode optionally drives fourth-port chip selects.
// - decode uses address, strobes, page, pin and logic feedback inputs.
// - general logic has 16 output and 16 input cells.
// - processor loads and reads output cells at run time.
// - all 64 array inputs enter the AND array true and complemented.
// - each output cell ORs up to ten product terms.
// - each output cell is combinatorial or registered as configured.
// - output cells feed back and may drive second or third port pins.
// - input cells clock, latch or pass their pin input.
// - input cell contents are readable at any time.
// - each of 16 pins is driven by software or by logic, per pin.
// - an 8-bit page register is read, written and feeds the decode.
// - a 256-byte control block is reached by io strobe, low byte.
module dfp_memory (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [21:0] busAddr,
    input  wire logic [15:0] busWrData,
    input  wire logic        busWr,
    input  wire logic        busRd,
    output logic      [15:0] busRdData,
    input  wire logic        byteStrobe,
    input  wire logic        dataStrobe,
    input  wire logic        ioStrobe,
    input  wire logic        programStrobe,
    input  wire logic        extRd,
    input  wire logic        extWr,
    input  wire logic [16:0] extAddr,
    input  wire logic [7:0]  extWrData,
    output logic      [7:0]  extRdData,
    output logic             extDenied,
    input  wire logic [15:0] pinIn,
    output logic      [15:0] pinOut,
    output logic      [15:0] pinOe,
    input  wire logic        imcGatePin,
    output logic      [2:0]  chipSelOut,
    output logic      [7:0]  sectorSel,
    output logic             flashStandby,
    output logic             logicStandby
);
    typedef enum logic {ST_IDLE, ST_ERASE} dfp_erase_t;

    logic [7:0]  flashMem [dfp_pkg::FLASH_BYTES];
    dfp_erase_t  eraseStateFf;
    logic [16:0] eraseAddrFf;
    logic [16:0] eraseEndFf;
    logic        eraseAllFf;
    logic        secureFf;
    logic [7:0]  pageFf;
    logic        lowPowerFf;
    logic [15:0] srcFf;
    logic [15:0] doutFf;
    logic [15:0] oeFf;
    logic [5:0]  csEnFf;
    logic [15:0] busRdDataFf;
    logic [7:0]  extRdDataFf;
    logic        extDeniedFf;
    logic [15:0] pinMetaFf;
    logic [15:0] pinSyncFf;
    logic [1:0]  gateMetaFf;
    logic [1:0]  divCntFf;
    logic [31:0] extPrevFf;
    logic [15:0] omcOut;
    logic [15:0] imcOut;
    logic [31:0] extIn;
    logic [16:0] flashAddr;
    logic        ctrlHit;
    logic        flashHit;
    logic        busy;
    logic        regWr;
    logic        imcClkEn;
    logic [1:0]  omcLoadEn;
    logic        eraseDone;
    logic        eraseGo;

    // sector decode shared by bus selects and the exported selects
    function automatic logic [7:0] sectorDecode(input logic [21:0] a, input logic bs,
                                                input logic ds, input logic [7:0] pg);
        logic [7:0] s;
        s = 8'h00;
        if (bs && a[21:17] == 5'h00) begin
            s[a[16:14]] = 1'b1; // byte dma reaches all 128K directly
        end else if (ds && a[21:14] == 8'h00) begin
            s[pg[2:0]] = 1'b1; // overlay window paged by page register
        end
        return s;
    endfunction

    // control block decode, io strobe only
    assign ctrlHit   = ioStrobe && busAddr[21:8] == dfp_pkg::CTRL_BASE;
    // program strobe takes no part in any select
    assign sectorSel = sectorDecode(busAddr, byteStrobe, dataStrobe, pageFf);
    assign flashHit  = |sectorSel && !ctrlHit;
    assign flashAddr = byteStrobe ? busAddr[16:0] : {pageFf[2:0], busAddr[13:0]};
    assign busy      = eraseStateFf == ST_ERASE;
    assign regWr     = busWr && ctrlHit;
    assign eraseGo   = regWr && busAddr[7:0] == dfp_pkg::REG_ERASE &&
                       busWrData[dfp_pkg::ERASE_GO_BIT] && !busy;
    assign eraseDone = busy && eraseAddrFf == eraseEndFf;

    // flash array idles unless a processor access selects it
    assign flashStandby = !((busRd || busWr) && flashHit);

    // pin and gate synchronisers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pinMetaFf  <= dfp_pkg::RST_HALF;
            pinSyncFf  <= dfp_pkg::RST_HALF;
            gateMetaFf <= 2'b00;
        end else begin
            pinMetaFf  <= pinIn;
            pinSyncFf  <= pinMetaFf;
            gateMetaFf <= {gateMetaFf[0], imcGatePin};
        end
    end

    // divider for the input cell clock mode
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            divCntFf <= 2'b00;
        end else begin
            divCntFf <= (divCntFf == 2'(dfp_pkg::IMC_DIV - 1)) ? 2'b00 : divCntFf + 2'b01;
        end
    end
    assign imcClkEn = divCntFf == 2'(dfp_pkg::IMC_DIV - 1);

    // logic array inputs: page, address, data and io strobes
    assign extIn     = {pageFf, busAddr, dataStrobe, ioStrobe};
    assign omcLoadEn = {regWr && busAddr[7:0] == dfp_pkg::REG_OMC_HI,
                        regWr && busAddr[7:0] == dfp_pkg::REG_OMC_LO};

    // 16 output and 16 input cells
    dfp_logic_array u_array (
        .core_clk    (core_clk),
        .rst         (rst),
        .extIn       (extIn),
        .pinSync     (pinSyncFf),
        .imcClkEn    (imcClkEn),
        .imcGate     (gateMetaFf[1]),
        .omcLoadEn   (omcLoadEn),
        .omcLoadData (busWrData[7:0]),
        .omcOut      (omcOut),
        .imcOut      (imcOut)
    );

    // low-power standby while the 32 external array inputs hold still
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            extPrevFf <= 32'h0000_0000;
        end else begin
            extPrevFf <= extIn;
        end
    end
    assign logicStandby = lowPowerFf && extIn == extPrevFf;

    // fourth-port chip selects from address window or logic feedback
    genvar k;
    generate
        for (k = 0; k < dfp_pkg::CS_PINS; k++) begin : g_cs
            assign chipSelOut[k] = csEnFf[k] &&
                ((ioStrobe && busAddr[21:8] == dfp_pkg::CS_BASE + 14'(k)) ||
                 (csEnFf[dfp_pkg::CS_PINS + k] && omcOut[k] && imcOut[k]));
        end
    endgenerate

    // pin drive chosen per pin: logic or software
    assign pinOut = (srcFf & omcOut) | (~srcFf & doutFf);
    assign pinOe  = oeFf;

    // control registers, low byte of the io word
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pageFf     <= dfp_pkg::RST_BYTE;
            lowPowerFf <= 1'b0;
            srcFf      <= dfp_pkg::RST_HALF;
            doutFf     <= dfp_pkg::RST_HALF;
            oeFf       <= dfp_pkg::RST_HALF;
            csEnFf     <= 6'h00;
        end else if (regWr) begin
            case (busAddr[7:0])
                dfp_pkg::REG_PAGE:    pageFf <= busWrData[7:0];
                dfp_pkg::REG_POWER:   lowPowerFf <= busWrData[dfp_pkg::POWER_LOW_BIT];
                dfp_pkg::REG_SRC_LO:  srcFf[7:0] <= busWrData[7:0];
                dfp_pkg::REG_SRC_HI:  srcFf[15:8] <= busWrData[7:0];
                dfp_pkg::REG_DOUT_LO: doutFf[7:0] <= busWrData[7:0];
                dfp_pkg::REG_DOUT_HI: doutFf[15:8] <= busWrData[7:0];
                dfp_pkg::REG_OE_LO:   oeFf[7:0] <= busWrData[7:0];
                dfp_pkg::REG_OE_HI:   oeFf[15:8] <= busWrData[7:0];
                dfp_pkg::REG_CS_EN:   csEnFf <= {busWrData[6:4], busWrData[2:0]};
                default: ;
            endcase
        end
    end

    // security bit: set by software, cleared by full erase only
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            secureFf <= 1'b0;
        end else if (regWr && busAddr[7:0] == dfp_pkg::REG_SECURE && busWrData[0]) begin
            secureFf <= 1'b1;
        end else if (eraseDone && eraseAllFf) begin
            secureFf <= 1'b0;
        end
    end

    // erase sequencer, one byte per cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            eraseStateFf <= ST_IDLE;
            eraseAddrFf  <= 17'h0_0000;
            eraseEndFf   <= 17'h0_0000;
            eraseAllFf   <= 1'b0;
        end else begin
            case (eraseStateFf)
                ST_IDLE: begin
                    if (eraseGo) begin
                        eraseStateFf <= ST_ERASE;
                        eraseAllFf   <= busWrData[dfp_pkg::ERASE_ALL_BIT];
                        if (busWrData[dfp_pkg::ERASE_ALL_BIT]) begin
                            eraseAddrFf <= 17'h0_0000;
                            eraseEndFf  <= dfp_pkg::FLASH_LAST;
                        end else begin
                            eraseAddrFf <= {busWrData[2:0], 14'h0000};
                            eraseEndFf  <= {busWrData[2:0], 14'h0000} | dfp_pkg::SECT_LAST;
                        end
                    end
                end
                ST_ERASE: begin
                    eraseAddrFf <= eraseAddrFf + 17'h0_0001;
                    if (eraseDone) begin
                        eraseStateFf <= ST_IDLE;
                    end
                end
                default: eraseStateFf <= ST_IDLE;
            endcase
        end
    end

    // flash writes: erase fills, programming clears bits; bus data byte by strobe
    always_ff @(posedge core_clk) begin
        if (busy) begin
            flashMem[eraseAddrFf] <= dfp_pkg::ERASED_BYTE;
        end else if (busWr && flashHit) begin
            flashMem[flashAddr] <= flashMem[flashAddr] &
                                   (dataStrobe ? busWrData[15:8] : busWrData[7:0]);
        end else if (extWr && !secureFf) begin
            flashMem[extAddr] <= flashMem[extAddr] & extWrData;
        end
    end

    // bus read data, present only in the cycle after the read
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            busRdDataFf <= dfp_pkg::RST_HALF;
        end else if (busRd && flashHit) begin
            busRdDataFf <= dataStrobe ? {flashMem[flashAddr], 8'h00}
                                      : {8'h00, flashMem[flashAddr]};
        end else if (busRd && ctrlHit) begin
            case (busAddr[7:0])
                dfp_pkg::REG_PAGE:    busRdDataFf <= {8'h00, pageFf};
                dfp_pkg::REG_POWER:   busRdDataFf <= {15'h0000, lowPowerFf};
                dfp_pkg::REG_STATUS:  busRdDataFf <= {14'h0000, secureFf, busy};
                dfp_pkg::REG_OMC_LO:  busRdDataFf <= {8'h00, omcOut[7:0]};
                dfp_pkg::REG_OMC_HI:  busRdDataFf <= {8'h00, omcOut[15:8]};
                dfp_pkg::REG_IMC_LO:  busRdDataFf <= {8'h00, imcOut[7:0]};
                dfp_pkg::REG_IMC_HI:  busRdDataFf <= {8'h00, imcOut[15:8]};
                dfp_pkg::REG_SRC_LO:  busRdDataFf <= {8'h00, srcFf[7:0]};
                dfp_pkg::REG_SRC_HI:  busRdDataFf <= {8'h00, srcFf[15:8]};
                dfp_pkg::REG_DOUT_LO: busRdDataFf <= {8'h00, doutFf[7:0]};
                dfp_pkg::REG_DOUT_HI: busRdDataFf <= {8'h00, doutFf[15:8]};
                dfp_pkg::REG_OE_LO:   busRdDataFf <= {8'h00, oeFf[7:0]};
                dfp_pkg::REG_OE_HI:   busRdDataFf <= {8'h00, oeFf[15:8]};
                dfp_pkg::REG_PIN_LO:  busRdDataFf <= {8'h00, pinSyncFf[7:0]};
                dfp_pkg::REG_PIN_HI:  busRdDataFf <= {8'h00, pinSyncFf[15:8]};
                dfp_pkg::REG_CS_EN:   busRdDataFf <= {9'h000, csEnFf[5:3], 1'b0, csEnFf[2:0]};
                default:              busRdDataFf <= dfp_pkg::RST_HALF;
            endcase
        end else begin
            busRdDataFf <= dfp_pkg::RST_HALF;
        end
    end
    assign busRdData = busRdDataFf;

    // external programmer port, locked out by the security bit
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            extRdDataFf <= dfp_pkg::RST_BYTE;
            extDeniedFf <= 1'b0;
        end else begin
            extRdDataFf <= (extRd && !secureFf) ? flashMem[extAddr] : dfp_pkg::RST_BYTE;
            extDeniedFf <= (extRd || extWr) && secureFf;
        end
    end
    assign extRdData = extRdDataFf;
    assign extDenied = extDeniedFf;

    // checks
    a_program_silent: assert property (@(posedge core_clk) disable iff (rst)
        (busRd && programStrobe && !byteStrobe && !dataStrobe && !ioStrobe)
        |=> busRdData == 16'h0000) else $error("program strobe read answered");
    a_data_upper_byte: assert property (@(posedge core_clk) disable iff (rst)
        (busRd && dataStrobe && flashHit) |=> busRdData[7:0] == 8'h00)
        else $error("data strobe read used low byte");
    a_secure_denies: assert property (@(posedge core_clk) disable iff (rst)
        (extRd && secureFf) |=> (extDenied && extRdData == 8'h00))
        else $error("secured device answered programmer");
    a_secure_clear: assert property (@(posedge core_clk) disable iff (rst)
        $fell(secureFf) |-> $past(eraseAllFf) && $past(eraseDone))
        else $error("security bit cleared without full erase");
    a_standby_access: assert property (@(posedge core_clk) disable iff (rst)
        !flashStandby |-> (busRd || busWr) && (byteStrobe || dataStrobe))
        else $error("flash awake without a flash access");
    a_sector_onehot: assert property (@(posedge core_clk) disable iff (rst)
        $onehot0(sectorSel) && !(ctrlHit && |sectorSel))
        else $error("more than one select");
    a_erase_start: assert property (@(posedge core_clk) disable iff (rst)
        eraseGo |=> busy ##0 (busy [*8]))
        else $error("erase did not run");
    a_page_readback: assert property (@(posedge core_clk) disable iff (rst)
        (regWr && busAddr[7:0] == dfp_pkg::REG_PAGE) |=> pageFf == $past(busWrData[7:0]))
        else $error("page register write lost");
endmodule // dfp_memory
`default_nettype wire

/* dfp_pkg.sv */
`default_nettype none
package dfp_pkg;
    // sizes of the memory, bus and logic arrays
    localparam int ADDR_W      = 22;
    localparam int FLASH_AW    = 17;
    localparam int SECT_AW     = 14;
    localparam int SECTORS     = 8;
    localparam int FLASH_BYTES = 131072;
    localparam int CELLS       = 16;
    localparam int TERMS       = 10;
    localparam int ARR_IN      = 64;
    localparam int PINS        = 16;
    localparam int CS_PINS     = 3;

    // clock and input macrocell sample rate
    localparam int CLK_NS        = 5;
    localparam int IMC_SAMPLE_NS = 20;
    localparam int IMC_DIV       = IMC_SAMPLE_NS / CLK_NS;

    // decode windows on address bits 21..8
    localparam logic [13:0] CTRL_BASE = 14'h0000;
    localparam logic [13:0] CS_BASE   = 14'h0001;

    // control register offsets within the 256-byte block
    localparam logic [7:0] REG_PAGE    = 8'h00;
    localparam logic [7:0] REG_POWER   = 8'h01;
    localparam logic [7:0] REG_ERASE   = 8'h02;
    localparam logic [7:0] REG_STATUS  = 8'h03;
    localparam logic [7:0] REG_SECURE  = 8'h04;
    localparam logic [7:0] REG_OMC_LO  = 8'h05;
    localparam logic [7:0] REG_OMC_HI  = 8'h06;
    localparam logic [7:0] REG_IMC_LO  = 8'h07;
    localparam logic [7:0] REG_IMC_HI  = 8'h08;
    localparam logic [7:0] REG_SRC_LO  = 8'h09;
    localparam logic [7:0] REG_SRC_HI  = 8'h0A;
    localparam logic [7:0] REG_DOUT_LO = 8'h0B;
    localparam logic [7:0] REG_DOUT_HI = 8'h0C;
    localparam logic [7:0] REG_OE_LO   = 8'h0D;
    localparam logic [7:0] REG_OE_HI   = 8'h0E;
    localparam logic [7:0] REG_PIN_LO  = 8'h0F;
    localparam logic [7:0] REG_PIN_HI  = 8'h10;
    localparam logic [7:0] REG_CS_EN   = 8'h11;

    // field positions
    localparam int POWER_LOW_BIT   = 0;
    localparam int ERASE_ALL_BIT   = 3;
    localparam int ERASE_GO_BIT    = 7;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_SEC_BIT  = 1;
    localparam int CS_LOGIC_POS    = 4;

    // values after reset and erased contents
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [15:0] RST_HALF    = 16'h0000;
    localparam logic [7:0]  ERASED_BYTE = 8'hFF;
    localparam logic [16:0] SECT_LAST   = 17'h0_3FFF;
    localparam logic [16:0] FLASH_LAST  = 17'h1_FFFF;
endpackage
`default_nettype wire

/* dsp_flash_decode_pld_memory_bench.sv */
`default_nettype none
module dsp_flash_decode_pld_memory_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [3:0] SP_BYTE = 4'h1, SP_DATA = 4'h2, SP_IO = 4'h4, SP_PROG = 4'h8;
    logic        core_clk, rst, extRd, extWr, extDenied, flashStandby, logicStandby;
    logic        busWr, busRd;
    logic [21:0] busAddr;
    logic [15:0] busWrData, busRdData, pinIn, pinOut, pinOe, oeModel;
    logic [3:0]  space;
    logic [16:0] extAddr;
    logic [7:0]  extWrData, extRdData, sectorSel, pg, d, d2;
    logic [2:0]  chipSelOut, s;
    logic [13:0] off;
    logic [7:0]  flashModel [int];
    int          n_errors, check_count, polls;
    int          cycles = 0;

    dfp_dsp_model dsp_u (.core_clk(core_clk), .busRdData(busRdData), .busAddr(busAddr),
        .busWrData(busWrData), .busWr(busWr), .busRd(busRd), .space(space));
    dfp_memory dut_u (.core_clk(core_clk), .rst(rst), .busAddr(busAddr), .busWrData(busWrData),
        .busWr(busWr), .busRd(busRd), .busRdData(busRdData), .byteStrobe(space[0]),
        .dataStrobe(space[1]), .ioStrobe(space[2]), .programStrobe(space[3]), .extRd(extRd),
        .extWr(extWr), .extAddr(extAddr), .extWrData(extWrData), .extRdData(extRdData),
        .extDenied(extDenied), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .imcGatePin(1'b0), .chipSelOut(chipSelOut), .sectorSel(sectorSel),
        .flashStandby(flashStandby), .logicStandby(logicStandby));

    // 200 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] o, input logic [7:0] v);
        dsp_u.xfer(1'b1, SP_IO, {14'h0000, o}, {8'h00, v});
    endtask
    task automatic rreg(input logic [7:0] o);
        dsp_u.xfer(1'b0, SP_IO, {14'h0000, o}, 16'h0000);
    endtask
    // external programmer access, answer sampled the cycle after
    task automatic ext(input logic wr, input logic [16:0] a, input logic [7:0] v);
        @(posedge core_clk);
        extRd <= !wr;
        extWr <= wr;
        extAddr <= a;
        extWrData <= v;
        @(posedge core_clk);
        extRd <= 1'b0;
        extWr <= 1'b0;
        extWrData <= ~v;
        #1;
    endtask
    task automatic end_sim();
        if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // main sequence
    initial begin
        {rst, extRd, extWr, extAddr, extWrData, oeModel} = {1'b1, 43'h0};
        pinIn = 16'($urandom(22670));
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        #1 check(busRdData, 16'h0000);
        check(pinOe, 16'h0000);
        check({15'h0000, flashStandby}, 16'h0001);
        pg = 8'($urandom);
        wreg(dfp_pkg::REG_PAGE, pg);
        rreg(dfp_pkg::REG_PAGE);
        check(dsp_u.rdVal, {8'h00, pg});
        rreg(8'h80);
        check(dsp_u.rdVal, 16'h0000);
        // erase a random sector and poll until idle
        s = 3'($urandom);
        off = 14'($urandom);
        wreg(dfp_pkg::REG_ERASE, {5'h10, s});
        rreg(dfp_pkg::REG_STATUS);
        check(dsp_u.rdVal, 16'h0001);
        polls = 0;
        while (dsp_u.rdVal[0] === 1'b1 && polls < 10000) begin
            rreg(dfp_pkg::REG_STATUS);
            polls++;
        end
        check(dsp_u.rdVal, 16'h0000);
        flashModel[{s, off}] = 8'hFF;
        dsp_u.xfer(1'b0, SP_BYTE, {5'h00, s, off}, 16'h0000);
        check(dsp_u.rdVal, {8'h00, flashModel[{s, off}]});
        // paged data strobe write, then an overlapping byte strobe write
        d = 8'($urandom);
        d2 = 8'($urandom);
        wreg(dfp_pkg::REG_PAGE, {5'h00, s});
        dsp_u.xfer(1'b1, SP_DATA, {8'h00, off}, {d, 8'hA5});
        dsp_u.xfer(1'b1, SP_BYTE, {5'h00, s, off}, {8'h5A, d2});
        flashModel[{s, off}] &= d & d2;
        dsp_u.xfer(1'b0, SP_DATA, {8'h00, off}, 16'h0000);
        check(dsp_u.rdVal, {flashModel[{s, off}], 8'h00});
        dsp_u.xfer(1'b0, SP_PROG, {5'h00, s, off}, 16'h0000);
        check(dsp_u.rdVal, 16'h0000);
        // programmer access before and after securing
        ext(1'b0, {s, off}, 8'h00);
        check({extDenied, 7'h00, extRdData}, {8'h00, flashModel[{s, off}]});
        wreg(dfp_pkg::REG_SECURE, 8'h01);
        rreg(dfp_pkg::REG_STATUS);
        check(dsp_u.rdVal, 16'h0002);
        ext(1'b1, {s, off}, 8'h00);
        check({15'h0000, extDenied}, 16'h0001);
        ext(1'b0, {s, off}, 8'h00);
        check({extDenied, 7'h00, extRdData}, 16'h8000);
        dsp_u.xfer(1'b0, SP_BYTE, {5'h00, s, off}, 16'h0000);
        check(dsp_u.rdVal, {8'h00, flashModel[{s, off}]});
        // software-driven pins in both halves
        for (int i = 0; i < 2; i++) begin
            d = 8'($urandom);
            oeModel[8*i +: 8] = d;
            wreg(dfp_pkg::REG_OE_LO + 8'(i), d);
            wreg(dfp_pkg::REG_DOUT_LO + 8'(i), ~d);
            rreg(dfp_pkg::REG_PIN_LO + 8'(i));
            check(dsp_u.rdVal, {8'h00, pinIn[8*i +: 8]});
            rreg(dfp_pkg::REG_IMC_LO + 8'(i));
            check(dsp_u.rdVal, {8'h00, pinIn[8*i +: 8]});
        end
        check(pinOe, oeModel);
        check(pinOut, ~oeModel);
        // io window chip selects, seen while the strobe stands
        wreg(dfp_pkg::REG_CS_EN, 8'h07);
        for (int k = 0; k < 3; k++) begin
            fork
                dsp_u.xfer(1'b0, SP_IO, {dfp_pkg::CS_BASE + 14'(k), 8'h00}, 16'h0000);
                begin
                    @(posedge core_clk);
                    #1 check({13'h0000, chipSelOut}, 16'(1 << k));
                end
            join
            check({13'h0000, chipSelOut}, 16'h0000);
            check(dsp_u.rdVal, 16'h0000);
        end
        // low-power idle and back to fast
        wreg(dfp_pkg::REG_POWER, 8'h01);
        repeat (4) @(posedge core_clk);
        #1 check({15'h0000, logicStandby}, 16'h0001);
        wreg(dfp_pkg::REG_POWER, 8'h00);
        check({15'h0000, logicStandby}, 16'h0000);
        end_sim();
    end
endmodule // dsp_flash_decode_pld_memory_bench
`default_nettype wire
